//--- gcc_regs.svh
// Purpose: Constants for the gated counter compare unit
// Assumes: 20 MHz mclk
// Notes:   Timing, reset values and limits only; types live in gcc_pkg
`ifndef GCC_REGS_SVH
`define GCC_REGS_SVH

// ****************************************
// Timing
// ****************************************
`define GCC_CLK_PERIOD_NS 50
`define GCC_MS_NS         1000000
`define GCC_PULSE_STEP_MS 2

// ****************************************
// Reset values and limits
// ****************************************
`define GCC_COUNT_RST 32'h0000_0000
`define GCC_CMP_RST   32'h0000_0000
`define GCC_LATCH_RST 32'h0000_0000
`define GCC_HYST_MIN  8'h02
`define GCC_CNT_MAX   32'h7FFF_FFFF

`endif

//--- gcc_pkg.sv
// Purpose: Types for the gated counter compare unit
// Assumes: Constants come from gcc_regs.svh
// Notes:   Configuration travels as one packed struct
package gcc_pkg;

  typedef enum logic [0:0] {
    GCC_MODE_PERIODIC = 1'b0,
    GCC_MODE_ONCE     = 1'b1
  } gcc_count_mode_t;

  typedef enum logic [1:0] {
    GCC_DIR_NONE = 2'b00,
    GCC_DIR_UP   = 2'b01,
    GCC_DIR_DOWN = 2'b10
  } gcc_main_dir_t;

  typedef enum logic [0:0] {
    GCC_GATE_CANCEL = 1'b0,
    GCC_GATE_STOP   = 1'b1
  } gcc_gate_func_t;

  typedef enum logic [1:0] {
    GCC_OUT_NONE  = 2'b00,
    GCC_OUT_GE    = 2'b01,
    GCC_OUT_LE    = 2'b10,
    GCC_OUT_PULSE = 2'b11
  } gcc_out_mode_t;

  typedef enum logic [0:0] {
    GCC_PS_IDLE = 1'b0,
    GCC_PS_RUN  = 1'b1
  } gcc_pulse_state_t;

  typedef struct packed {
    gcc_count_mode_t    mode;
    gcc_main_dir_t      main_dir;
    gcc_gate_func_t     gate_func;
    logic               hardware_gate_input_en;
    gcc_out_mode_t      out_mode;
    logic [7:0]         hysteresis;
    logic [7:0]         pulse_steps;
    logic signed [31:0] load_value;
    logic signed [31:0] end_value;
  } gcc_cfg_t;

endpackage

//--- gcc_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to mclk
// Notes:   Output changes once stages two and three agree
`timescale 1ns/100ps
module gcc_sync #(
  parameter int W = 4
) (
  input  wire logic         mclk,    // System clock
  input  wire logic         reset_n, // Async reset
  input  wire logic [W-1:0] pin,     // Raw pins
  output logic      [W-1:0] level    // Filtered level
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        s1_reg[i] <= 1'b0;
        s2_reg[i] <= 1'b0;
        s3_reg[i] <= 1'b0;
        level[i]  <= 1'b0;
      end else begin
        s1_reg[i] <= pin[i];
        s2_reg[i] <= s1_reg[i];
        s3_reg[i] <= s2_reg[i];
        if (s2_reg[i] == s3_reg[i]) begin
          level[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule

//--- gcc_ms_tick.sv
// Purpose: Millisecond tick for pulse timing
// Assumes: CYCLES clocks per millisecond
// Notes:   Restart realigns the tick to the pulse start
`timescale 1ns/100ps
module gcc_ms_tick #(
  parameter int unsigned CYCLES = 20000
) (
  input  wire logic mclk,    // System clock
  input  wire logic reset_n, // Async reset
  input  wire logic restart, // Realign divider
  output logic      tick     // One-cycle ms pulse
);
  logic [31:0] div_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= 32'h0000_0000;
      tick    <= 1'b0;
    end else if (restart) begin
      // Trigger cycle counts as the first, tick is registered
      div_reg <= 32'h0000_0001;
      tick    <= 1'b0;
    end else if (div_reg == CYCLES - 32'h0000_0001) begin
      div_reg <= 32'h0000_0000;
      tick    <= 1'b1;
    end else begin
      div_reg <= div_reg + 32'h0000_0001;
      tick    <= 1'b0;
    end
  end
endmodule

//--- gcc_counter.sv
// Purpose: Gated up/down counter with latch, comparator and pulse output
// Assumes: Encoder pins asynchronous; config and program bits on mclk
// Notes:   Direction pin high means count down
`timescale 1ns/100ps
`include "gcc_regs.svh"

module gcc_counter
  import gcc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `GCC_MS_NS / `GCC_CLK_PERIOD_NS
) (
  input  wire logic               mclk,                   // System clock
  input  wire logic               reset_n,                // Async reset
  input  wire logic               count_pulse_pin,        // Encoder pulse pin
  input  wire logic               count_dir_pin,          // Encoder direction pin
  input  wire logic               hardware_gate_input,    // Hardware gate pin
  input  wire logic               latch_pin,              // Latch pin
  input  wire gcc_cfg_t           cfg,                    // Channel configuration
  input  wire logic               software_gate_bit,      // Program gate
  input  wire logic               output_control,         // Output enable bit
  input  wire logic               plain_out,              // Output in no-compare mode
  input  wire logic               cmp_wr_en,              // Comparison value write
  input  wire logic signed [31:0] cmp_wr_data,            // Comparison value data
  input  wire logic               cmp_flag_clear,         // Clear request for flag
  output logic signed      [31:0] count_value,            // Counter value
  output logic signed      [31:0] captured_count_value,   // Latched count
  output logic signed      [31:0] cmp_value,              // Comparison value
  output logic                    internal_gate,          // Internal gate state
  output logic                    digital_out,            // Channel output
  output logic                    output_state_indicator, // Output state
  output logic                    output_state_flag,      // Output status bit
  output logic                    comparator_result_flag  // Comparator status bit
);

  // ****************************************
  // Pin synchronisation and edges
  // ****************************************
  logic [3:0] pin_level;
  logic [3:0] pin_prev_reg;
  logic       sw_prev_reg;
  logic       a_rise;
  logic       dir_down;
  logic       hw_level;
  logic       hw_rise;
  logic       latch_rise;
  logic       sw_rise;

  gcc_sync #(.W(4)) u_sync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .pin     ({latch_pin, hardware_gate_input, count_dir_pin, count_pulse_pin}),
    .level   (pin_level)
  );

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_prev_reg <= 4'h0;
      sw_prev_reg  <= 1'b0;
    end else begin
      pin_prev_reg <= pin_level;
      sw_prev_reg  <= software_gate_bit;
    end
  end

  assign a_rise     = pin_level[0] & ~pin_prev_reg[0];
  assign dir_down   = pin_level[1];
  assign hw_level   = pin_level[2];
  assign hw_rise    = pin_level[2] & ~pin_prev_reg[2];
  assign latch_rise = pin_level[3] & ~pin_prev_reg[3];
  assign sw_rise    = software_gate_bit & ~sw_prev_reg;

  // ****************************************
  // Gate control
  // ****************************************
  logic auto_closed_reg;
  logic once_close;
  logic reopen;
  logic restart_load;
  logic gate_open;
  logic step;

  assign reopen = cfg.hardware_gate_input_en ? (hw_rise & software_gate_bit) : sw_rise;
  assign restart_load = (cfg.gate_func == GCC_GATE_CANCEL) &
                        (cfg.hardware_gate_input_en ? (hw_rise & software_gate_bit) : sw_rise);
  assign gate_open = software_gate_bit & (~cfg.hardware_gate_input_en | hw_level) & ~auto_closed_reg;
  assign step      = a_rise & gate_open;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      auto_closed_reg <= 1'b0;
    end else if (once_close) begin
      auto_closed_reg <= 1'b1;
    end else if (reopen) begin
      auto_closed_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      internal_gate <= 1'b0;
    end else begin
      internal_gate <= gate_open;
    end
  end

  // ****************************************
  // Counter
  // ****************************************
  logic signed [31:0] count_next;
  logic               last_down_reg;

  always_comb begin
    count_next = count_value;
    once_close = 1'b0;
    if (restart_load) begin
      count_next = cfg.load_value;
    end else if (step && !dir_down) begin
      if (cfg.main_dir == GCC_DIR_UP && count_value == cfg.end_value - 32'sd1) begin
        count_next = cfg.load_value;
        once_close = (cfg.mode == GCC_MODE_ONCE);
      end else begin
        count_next = count_value + 32'sd1;
        once_close = (cfg.mode == GCC_MODE_ONCE) && (cfg.main_dir == GCC_DIR_NONE) &&
                     (count_value == `GCC_CNT_MAX);
      end
    end else if (step && dir_down) begin
      if (cfg.main_dir == GCC_DIR_DOWN && count_value == cfg.end_value + 32'sd1) begin
        count_next = cfg.load_value;
        once_close = (cfg.mode == GCC_MODE_ONCE);
      end else begin
        count_next = count_value - 32'sd1;
        once_close = (cfg.mode == GCC_MODE_ONCE) && (cfg.main_dir == GCC_DIR_NONE) &&
                     (count_value == ~`GCC_CNT_MAX);
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_value <= `GCC_COUNT_RST;
    end else begin
      count_value <= count_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      last_down_reg <= 1'b0;
    end else if (step) begin
      last_down_reg <= dir_down;
    end
  end

  // ****************************************
  // Latch
  // ****************************************
  // No clear besides reset, so a run transition keeps the value
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      captured_count_value <= `GCC_LATCH_RST;
    end else if (latch_rise && gate_open) begin
      captured_count_value <= count_value;
    end
  end

  // ****************************************
  // Comparison value and hysteresis
  // ****************************************
  logic               raw_cond;
  logic               raw_prev_reg;
  logic               dir_ok;
  logic               cmp_res;
  logic               hyst_active_reg;
  logic signed [31:0] hyst_lo_reg;
  logic signed [31:0] hyst_hi_reg;
  logic signed [31:0] hyst_ext;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmp_value <= `GCC_CMP_RST;
    end else if (cmp_wr_en) begin
      cmp_value <= cmp_wr_data;
    end
  end

  assign dir_ok = (cfg.main_dir == GCC_DIR_NONE) ||
                  (cfg.main_dir == GCC_DIR_UP && !last_down_reg) ||
                  (cfg.main_dir == GCC_DIR_DOWN && last_down_reg);

  always_comb begin
    case (cfg.out_mode)
      GCC_OUT_GE: begin
        raw_cond = (count_value >= cmp_value);
      end
      GCC_OUT_LE: begin
        raw_cond = (count_value <= cmp_value);
      end
      GCC_OUT_PULSE: begin
        raw_cond = (count_value == cmp_value) && dir_ok;
      end
      default: begin
        raw_cond = 1'b0;
      end
    endcase
  end

  assign hyst_ext = signed'({24'h00_0000, cfg.hysteresis});
  assign cmp_res  = raw_cond | hyst_active_reg;

  // Range is captured at activation so a new setting waits
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hyst_active_reg <= 1'b0;
      hyst_lo_reg     <= `GCC_COUNT_RST;
      hyst_hi_reg     <= `GCC_COUNT_RST;
    end else if (!hyst_active_reg) begin
      if (raw_cond && cfg.hysteresis >= `GCC_HYST_MIN) begin
        hyst_active_reg <= 1'b1;
        hyst_lo_reg     <= count_value - hyst_ext;
        hyst_hi_reg     <= count_value + hyst_ext;
      end
    end else if (count_value < hyst_lo_reg || count_value > hyst_hi_reg) begin
      hyst_active_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      raw_prev_reg <= 1'b0;
    end else begin
      raw_prev_reg <= raw_cond;
    end
  end

  // ****************************************
  // Pulse timer
  // ****************************************
  gcc_pulse_state_t pulse_state_reg;
  logic [8:0]       pulse_left_reg;
  logic             ms_tick;
  logic             trigger;
  logic             dur_zero;

  assign dur_zero = (cfg.pulse_steps == 8'h00);
  assign trigger = (cfg.out_mode == GCC_OUT_PULSE) && output_control && !dur_zero &&
                   raw_cond && !raw_prev_reg && !hyst_active_reg &&
                   (pulse_state_reg == GCC_PS_IDLE);

  gcc_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
    .mclk    (mclk),
    .reset_n (reset_n),
    .restart (trigger),
    .tick    (ms_tick)
  );

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_state_reg <= GCC_PS_IDLE;
      pulse_left_reg  <= 9'h000;
    end else begin
      case (pulse_state_reg)
        GCC_PS_IDLE: begin
          if (trigger) begin
            pulse_state_reg <= GCC_PS_RUN;
            pulse_left_reg  <= 9'(cfg.pulse_steps * `GCC_PULSE_STEP_MS);
          end
        end
        GCC_PS_RUN: begin
          if (ms_tick) begin
            if (pulse_left_reg == 9'h001) begin
              pulse_state_reg <= GCC_PS_IDLE;
              pulse_left_reg  <= 9'h000;
            end else begin
              pulse_left_reg <= pulse_left_reg - 9'h001;
            end
          end
        end
        default: begin
          pulse_state_reg <= GCC_PS_IDLE;
          pulse_left_reg  <= 9'h000;
        end
      endcase
    end
  end

  // ****************************************
  // Output and status
  // ****************************************
  logic do_next;
  logic flag_set;
  logic flag_clr_ok;

  always_comb begin
    case (cfg.out_mode)
      GCC_OUT_NONE: begin
        do_next     = plain_out;
        flag_set    = 1'b0;
        flag_clr_ok = 1'b1;
      end
      GCC_OUT_PULSE: begin
        if (dur_zero) begin
          do_next     = output_control & cmp_res;
          flag_set    = cmp_res;
          flag_clr_ok = !cmp_res;
        end else begin
          do_next     = trigger | (pulse_state_reg == GCC_PS_RUN && !(ms_tick && pulse_left_reg == 9'h001));
          flag_set    = trigger;
          flag_clr_ok = (pulse_state_reg == GCC_PS_IDLE);
        end
      end
      default: begin
        do_next     = output_control & cmp_res;
        flag_set    = cmp_res;
        flag_clr_ok = !cmp_res;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      digital_out            <= 1'b0;
      output_state_indicator <= 1'b0;
      output_state_flag      <= 1'b0;
    end else begin
      digital_out            <= do_next;
      output_state_indicator <= do_next;
      output_state_flag      <= (cfg.out_mode != GCC_OUT_NONE) & do_next;
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      comparator_result_flag <= 1'b0;
    end else if (cfg.out_mode == GCC_OUT_NONE) begin
      comparator_result_flag <= 1'b0;
    end else if (flag_set) begin
      comparator_result_flag <= 1'b1;
    end else if (cmp_flag_clear && flag_clr_ok) begin
      comparator_result_flag <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_up_reload: assert property (step && !dir_down && !restart_load && cfg.main_dir == GCC_DIR_UP &&
    count_value == cfg.end_value - 32'sd1 |=> count_value == $past(cfg.load_value))
    else $error("up reload missed");
  a_down_reload: assert property (step && dir_down && !restart_load && cfg.main_dir == GCC_DIR_DOWN &&
    count_value == cfg.end_value + 32'sd1 |=> count_value == $past(cfg.load_value))
    else $error("down reload missed");
  a_down_exceed: assert property (step && !dir_down && !restart_load && cfg.main_dir == GCC_DIR_DOWN
    |=> count_value == $past(count_value) + 32'sd1)
    else $error("up count blocked in down direction");
  a_gate_hold: assert property (!gate_open && !restart_load |=> $stable(count_value))
    else $error("count moved with gate closed");
  a_cancel_load: assert property (restart_load |=> count_value == $past(cfg.load_value))
    else $error("cancel did not reload");
  a_stop_resume: assert property (cfg.gate_func == GCC_GATE_STOP && sw_rise && !a_rise |=>
    $stable(count_value))
    else $error("stop gate changed count");
  a_latch_copy: assert property (latch_rise && gate_open |=> captured_count_value == $past(count_value))
    else $error("latch copy wrong");
  a_none_flags: assert property (cfg.out_mode == GCC_OUT_NONE ##1 cfg.out_mode == GCC_OUT_NONE |->
    !comparator_result_flag && !output_state_flag)
    else $error("flags set with no comparison");
  a_ge_output: assert property ((cfg.out_mode == GCC_OUT_GE) && output_control && cmp_res |=>
    digital_out && comparator_result_flag)
    else $error("ge output not asserted");
  a_clear_block: assert property ((cfg.out_mode == GCC_OUT_LE) && cmp_res && comparator_result_flag
    |=> comparator_result_flag)
    else $error("flag cleared while condition holds");
  a_pulse_load: assert property (trigger |=> pulse_left_reg == 9'($past(cfg.pulse_steps) * 2) && digital_out)
    else $error("pulse length not loaded");
  a_pulse_noretrig: assert property (pulse_state_reg == GCC_PS_RUN && !ms_tick |=>
    pulse_left_reg == $past(pulse_left_reg))
    else $error("pulse retriggered");
  a_hyst_freeze: assert property (hyst_active_reg && count_value >= hyst_lo_reg &&
    count_value <= hyst_hi_reg |=> hyst_active_reg)
    else $error("result changed inside hysteresis");

  c_reload_up: cover property (step && cfg.main_dir == GCC_DIR_UP && count_value == cfg.end_value - 32'sd1);
  c_pulse_done: cover property (pulse_state_reg == GCC_PS_RUN ##1 pulse_state_reg == GCC_PS_IDLE);
  c_hyst_on: cover property ($rose(hyst_active_reg));
  c_once_close: cover property ($rose(auto_closed_reg));

endmodule

//--- gcc_pins_model.sv
// Purpose: Pin-side model of encoder pulse, direction, gate and latch
// Assumes: Pins move just after mclk rising edges
// Notes:   Every level is held six cycles, longer than the pin filter
`timescale 1ns/100ps
module gcc_pins_model (
  input  wire logic mclk,      // System clock
  output logic      pulse_pin, // Count pulse
  output logic      dir_pin,   // Direction, high is down
  output logic      gate_pin,  // Hardware gate
  output logic      latch_pin  // Latch
);
  initial begin
    pulse_pin = 1'b0;
    dir_pin   = 1'b0;
    gate_pin  = 1'b0;
    latch_pin = 1'b0;
  end

  task automatic hold();
    repeat (6) @(posedge mclk);
  endtask

  // One full count pulse in the given direction
  task automatic step(input logic down);
    @(posedge mclk);
    dir_pin <= down;
    hold();
    pulse_pin <= 1'b1;
    hold();
    pulse_pin <= 1'b0;
    hold();
  endtask

  task automatic gate(input logic v);
    @(posedge mclk);
    gate_pin <= v;
    hold();
  endtask

  task automatic latch();
    @(posedge mclk);
    latch_pin <= 1'b1;
    hold();
    latch_pin <= 1'b0;
    hold();
  endtask
endmodule

//--- tb.sv
// Purpose: Self-checking bench for the gated counter compare unit
// Assumes: Pin model drives the encoder side
// Notes:   Short millisecond divider keeps pulse runs brief
`timescale 1ns/100ps
module tb;
  import gcc_pkg::*;
  localparam int MS = 10;
  logic               mclk, reset_n, pulse_pin, dir_pin, gate_pin, latch_pin;
  gcc_cfg_t           cfg;
  logic               software_gate_bit, output_control, plain_out, cmp_wr_en, cmp_flag_clear;
  logic signed [31:0] cmp_wr_data, count_value, captured_count_value, cmp_value;
  logic               internal_gate, digital_out, output_state_indicator;
  logic               output_state_flag, comparator_result_flag;
  int                 num_errors = 0;
  int                 cmp_count = 0;
  int                 cycles = 0;
  int                 hi_len = 0;
  int                 last_len = 0;

  gcc_counter #(.MS_CYCLES(MS)) gcc_counter_inst (
    .mclk(mclk),
    .reset_n(reset_n),
    .count_pulse_pin(pulse_pin),
    .count_dir_pin(dir_pin),
    .hardware_gate_input(gate_pin),
    .latch_pin(latch_pin),
    .cfg(cfg),
    .software_gate_bit(software_gate_bit),
    .output_control(output_control),
    .plain_out(plain_out),
    .cmp_wr_en(cmp_wr_en),
    .cmp_wr_data(cmp_wr_data),
    .cmp_flag_clear(cmp_flag_clear),
    .count_value(count_value),
    .captured_count_value(captured_count_value),
    .cmp_value(cmp_value),
    .internal_gate(internal_gate),
    .digital_out(digital_out),
    .output_state_indicator(output_state_indicator),
    .output_state_flag(output_state_flag),
    .comparator_result_flag(comparator_result_flag));

  gcc_pins_model gcc_pins_model_inst (
    .mclk(mclk),
    .pulse_pin(pulse_pin),
    .dir_pin(dir_pin),
    .gate_pin(gate_pin),
    .latch_pin(latch_pin));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ****************************************
  // Output pulse width and timeout
  // ****************************************
  always @(posedge mclk) begin
    cycles++;
    if (digital_out === 1'b1) begin
      hi_len++;
    end else if (hi_len != 0) begin
      last_len = hi_len;
      hi_len = 0;
    end
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic sw(input logic v);
    @(posedge mclk);
    software_gate_bit <= v;
    repeat (3) @(posedge mclk);
  endtask

  task automatic wr_cmp(input logic signed [31:0] v);
    @(posedge mclk);
    cmp_wr_en   <= 1'b1;
    cmp_wr_data <= v;
    @(posedge mclk);
    cmp_wr_en <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("cmp_value", cmp_value, v);
  endtask

  task automatic clr_flag();
    @(posedge mclk);
    cmp_flag_clear <= 1'b1;
    @(posedge mclk);
    cmp_flag_clear <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic t_up();
    logic [31:0] exp [3] = '{32'h0000_0006, 32'h0000_0007, 32'h0000_0005};
    sw(1'b0);
    sw(1'b1);
    chk("count start", count_value, 32'h0000_0005);
    for (int i = 0; i < 3; i++) begin
      gcc_pins_model_inst.step(1'b0);
      chk("count up", count_value, exp[i]);
    end
  endtask

  task automatic t_down();
    logic [31:0] exp [3] = '{32'h0000_0004, 32'h0000_0003, 32'h0000_0005};
    @(posedge mclk);
    cfg.main_dir  <= GCC_DIR_DOWN;
    cfg.end_value <= 32'sh0000_0002;
    for (int i = 0; i < 3; i++) begin
      gcc_pins_model_inst.step(1'b1);
      chk("count down", count_value, exp[i]);
    end
    gcc_pins_model_inst.step(1'b0);
    chk("count against dir", count_value, 32'h0000_0006);
  endtask

  task automatic t_gate();
    @(posedge mclk);
    cfg.gate_func <= GCC_GATE_STOP;
    sw(1'b0);
    chk("gate closed", internal_gate, 1'b0);
    gcc_pins_model_inst.step(1'b0);
    chk("count gated", count_value, 32'h0000_0006);
    sw(1'b1);
    chk("count resumed", count_value, 32'h0000_0006);
    chk("gate open", internal_gate, 1'b1);
  endtask

  task automatic t_hw();
    @(posedge mclk);
    cfg.hardware_gate_input_en <= 1'b1;
    cfg.gate_func  <= GCC_GATE_CANCEL;
    gcc_pins_model_inst.step(1'b1);
    chk("hardware_gate_input low", count_value, 32'h0000_0006);
    gcc_pins_model_inst.gate(1'b1);
    chk("hw rise cancel", count_value, 32'h0000_0005);
    gcc_pins_model_inst.step(1'b1);
    sw(1'b0);
    sw(1'b1);
    chk("sw rise hw high", count_value, 32'h0000_0004);
    gcc_pins_model_inst.gate(1'b0);
    gcc_pins_model_inst.step(1'b1);
    chk("hw fall closes", count_value, 32'h0000_0004);
  endtask

  task automatic t_latch();
    gcc_pins_model_inst.gate(1'b1);
    gcc_pins_model_inst.latch();
    chk("latched", captured_count_value, 32'h0000_0005);
    gcc_pins_model_inst.step(1'b1);
    chk("latch kept", captured_count_value, 32'h0000_0005);
  endtask

  task automatic t_cmp();
    @(posedge mclk);
    cfg.out_mode   <= GCC_OUT_GE;
    output_control <= 1'b1;
    wr_cmp(32'sh0000_0004);
    chk("ge out", digital_out, 1'b1);
    clr_flag();
    chk("ge flag held", comparator_result_flag, 1'b1);
    gcc_pins_model_inst.step(1'b1);
    chk("ge out low", digital_out, 1'b0);
    clr_flag();
    chk("ge flag clr", comparator_result_flag, 1'b0);
    @(posedge mclk);
    cfg.out_mode <= GCC_OUT_LE;
    repeat (3) @(posedge mclk);
    chk("le out", digital_out, 1'b1);
    chk("le sts", output_state_flag, 1'b1);
    chk("le cmp", comparator_result_flag, 1'b1);
    @(posedge mclk);
    cfg.out_mode <= GCC_OUT_NONE;
    plain_out    <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("plain out", digital_out, 1'b1);
    chk("plain sts", output_state_flag, 1'b0);
    chk("plain cmp", comparator_result_flag, 1'b0);
    chk("plain ind", output_state_indicator, 1'b1);
  endtask

  task automatic t_pulse();
    @(posedge mclk);
    plain_out        <= 1'b0;
    cfg.main_dir     <= GCC_DIR_UP;
    cfg.end_value    <= 32'sh0000_0008;
    cfg.hardware_gate_input_en   <= 1'b0;
    cfg.pulse_steps  <= 8'h01;
    sw(1'b0);
    sw(1'b1);
    wr_cmp(32'sh0000_0006);
    @(posedge mclk);
    cfg.out_mode <= GCC_OUT_PULSE;
    gcc_pins_model_inst.step(1'b0);
    chk("pulse flag", comparator_result_flag, 1'b1);
    repeat (40) @(posedge mclk);
    chk("pulse width", last_len, 2 * MS);
  endtask

  // Range 4..8 captured at count 6; wider setting must wait
  task automatic t_hyst();
    @(posedge mclk);
    cfg.out_mode   <= GCC_OUT_GE;
    cfg.hysteresis <= 8'h02;
    repeat (3) @(posedge mclk);
    cfg.hysteresis <= 8'h10;
    for (int i = 0; i < 2; i++) begin
      gcc_pins_model_inst.step(1'b1);
      chk("hyst held", digital_out, 1'b1);
    end
    gcc_pins_model_inst.step(1'b1);
    chk("hyst left", digital_out, 1'b0);
  endtask

  task automatic t_once();
    @(posedge mclk);
    cfg.mode       <= GCC_MODE_ONCE;
    cfg.hardware_gate_input_en <= 1'b1;
    cfg.end_value  <= 32'sh0000_0005;
    gcc_pins_model_inst.step(1'b0);
    gcc_pins_model_inst.step(1'b0);
    chk("once reload", count_value, 32'h0000_0005);
    sw(1'b0);
    sw(1'b1);
    gcc_pins_model_inst.step(1'b0);
    chk("once closed", count_value, 32'h0000_0005);
    gcc_pins_model_inst.gate(1'b0);
    gcc_pins_model_inst.gate(1'b1);
    gcc_pins_model_inst.step(1'b0);
    chk("once reopened", count_value, 32'h0000_0006);
  endtask

  initial begin
    reset_n = 1'b0;
    cfg = '{GCC_MODE_PERIODIC, GCC_DIR_UP, GCC_GATE_CANCEL, 1'b0, GCC_OUT_NONE, 8'h00, 8'h00,
            32'sh0000_0005, 32'sh0000_0008};
    software_gate_bit = 1'b0;
    output_control    = 1'b0;
    plain_out         = 1'b0;
    cmp_wr_en         = 1'b0;
    cmp_wr_data       = 32'sh0000_0000;
    cmp_flag_clear    = 1'b0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_up();
    t_down();
    t_gate();
    t_hw();
    t_latch();
    t_cmp();
    t_pulse();
    t_hyst();
    t_once();
    print_verdict();
  end
endmodule
